// ==== logic/gpt_pkg.sv ====
`default_nettype none
package gpt_pkg;
  // Timer indices: module A low aux, core, high aux; module B aux, core.
  localparam int NUM_TMR = 5;
  localparam int T_A_LOW = 0;
  localparam int T_A_CORE = 1;
  localparam int T_A_HIGH = 2;
  localparam int T_B_AUX = 3;
  localparam int T_B_CORE = 4;
  // Bus clock period and finest count periods, in nanoseconds.
  localparam int CLK_NS = 25;
  localparam int A_MIN_NS = 500;
  localparam int B_MIN_NS = 250;
  // The finest periods hold at this reference clock, so they are a fixed
  // number of clocks per step and scale with whatever clock runs the block.
  localparam int REF_MHZ = 16;
  localparam int NS_PER_US = 1000;
  localparam int A_BASE_CYC = A_MIN_NS * REF_MHZ / NS_PER_US;
  localparam int B_BASE_CYC = B_MIN_NS * REF_MHZ / NS_PER_US;
  // Byte offsets of the register map.
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CNT0 = 8'h20;
  localparam logic [7:0] OFS_CAP_RELOAD = 8'h40;
  localparam logic [7:0] OFS_FLAGS = 8'h44;
  localparam logic [7:0] OFS_STEP = 8'h04;
  // Control word fields.
  localparam int F_PRE_LO = 0;
  localparam int F_PRE_HI = 2;
  localparam int F_MODE_LO = 3;
  localparam int F_MODE_HI = 4;
  localparam int F_RUN = 5;
  localparam int F_DOWN = 6;
  localparam int F_XDIR = 7;
  localparam int F_GPOL = 8;
  localparam int F_FUNC_LO = 9;
  localparam int F_FUNC_HI = 10;
  localparam int F_TRIG_TOG = 11;
  localparam int F_TOG_FALL = 12;
  localparam int F_OPT = 13;
  localparam int F_OPT2 = 14;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam int CAP_FLAG = 5;
  typedef enum logic [1:0] {
    GPT_TIMER = 2'b00,
    GPT_GATED = 2'b01,
    GPT_COUNTER = 2'b11,
    GPT_TOGGLE = 2'b10
  } gpt_mode_t;
  typedef enum logic [1:0] {
    GPT_FN_COUNT = 2'b00,
    GPT_FN_RELOAD = 2'b01,
    GPT_FN_CAPTURE = 2'b10
  } gpt_func_t;
endpackage
`default_nettype wire

// ==== logic/gpt_timer_units.sv ====
// What this block does
// - Module A timers pick timer, gated, counter mode.
// - Timer mode counts prescaled bus clock ticks.
// - Counter mode counts edges on timer pin.
// - Gated mode counts ticks while gate level active.
// - Module A finest period is 8 clocks, 500 ns at 16 MHz.
// - Software direction, optionally flipped by pin.
// - Core A toggle latch flips on wrap.
// - Core A latch drives pin, clocks aux timers.
// - Aux timers as reload/capture stop counting.
// - Capture copies core A into aux timer.
// - Reload core A from pin or latch edge.
// - Opposite-edge reloads give continuous PWM.
// - Timers chain within module, else independent.
// - Module B: two timers, capture register, 4 clocks (250 ns at 16 MHz).
// - Module B prescaled, software up/down.
// - Core B latch flips on wrap, clocks aux.
// - Core B wrap optionally reloads from capture register.
// - Capture pin edge copies aux B, optional clear.
`timescale 1ns/1ps
`default_nettype none

// One 16-bit up/down counter with a synchronous load.
// Every timer of both modules is one of these, so wrap detection and
// load priority behave the same everywhere.
module gpt_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic down,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] count_ff,
  output logic wrap
);
  import gpt_pkg::*;

  // A wrap is a step out of the last value in the current direction.
  // The pulse is combinational, so the latch and any reload act in the same cycle.
  assign wrap = step & (down ? (count_ff == 16'h0000) : (count_ff == 16'hFFFF));

  // Load wins over counting so reloads replace the wrapped value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= CNT_RST;
    end else if (load) begin
      count_ff <= load_val;
    end else if (step) begin
      count_ff <= down ? count_ff - 16'h0001 : count_ff + 16'h0001;
    end
  end
endmodule

module gpt_timer_units (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] timer_gate_clock_in,
  input wire logic [2:0] timer_dir_in,
  input wire logic capture_trigger_in,
  output logic core_a_toggle_out,
  output logic [5:0] timer_flags
);
  import gpt_pkg::*;

  // Per-timer state is kept in arrays indexed by the package's timer numbers.
  logic [15:0] ctrl_ff [NUM_TMR]; // Per-timer control words.
  logic [15:0] cnt [NUM_TMR]; // Counter values.
  logic [15:0] ld_val [NUM_TMR]; // Load values per counter.
  logic [NUM_TMR-1:0] step; // Count strobes.
  logic [NUM_TMR-1:0] down; // Effective directions.
  logic [NUM_TMR-1:0] ld; // Load strobes.
  logic [NUM_TMR-1:0] wrap; // Overflow or underflow pulses.
  logic [NUM_TMR-1:0] sw_cnt_wr; // Software writes to counters.
  logic [15:0] capture_reload_ff; // Capture/reload register.
  logic core_a_toggle_latch_ff; // Core A toggle latch.
  logic core_b_toggle_latch_ff; // Core B toggle latch.
  logic [5:0] flags_ff; // Request flags.
  logic [5:0] flag_set; // Hardware set terms.
  logic [2:0] pin_d_ff; // Previous pin levels for edges.
  logic [2:0] pin_rise; // Rising edges on module A pins.
  logic cap_d_ff; // Previous capture pin level.
  logic cap_event; // Selected capture pin transition.
  logic [4:0] base_a_ff; // Module A base divider.
  logic [4:0] base_b_ff; // Module B base divider.
  logic base_a_tick; // One finest period of module A.
  logic base_b_tick; // One finest period of module B.
  logic [7:0] pre_a_ff; // Module A prescaler chain.
  logic [7:0] pre_b_ff; // Module B prescaler chain.
  logic tog_a_rise; // Core A latch going high.
  logic tog_a_fall; // Core A latch going low.
  logic wr_en; // Register write in access phase.
  logic rd_setup; // Read in setup phase.
  logic addr_ok; // Address decodes to a register.
  logic [31:0] rd_mux; // Read data before the output flop.

  // Terminal counts of the base dividers; each divider restarts after it.
  localparam logic [4:0] A_LAST = 5'(A_BASE_CYC - 1);
  localparam logic [4:0] B_LAST = 5'(B_BASE_CYC - 1);

  // A prescaler setting p selects every 2**p-th base tick.
  // The chain counts base ticks, so setting p needs its low p bits all set.
  // Setting 7 gives the slowest rate, one step in 128 base periods.
  function automatic logic pre_tick(input logic base, input logic [7:0] chain,
                                    input logic [2:0] p);
    logic [7:0] mask;
    mask = (8'h01 << p) - 8'h01;
    pre_tick = base & ((chain & mask) == mask);
  endfunction

  // Base dividers give the finest count period of each module.
  // The chain runs free from reset, so the first step after a control write
  // may come anywhere within one prescaled period; software must allow for it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_a_ff <= 5'h00;
      pre_a_ff <= 8'h00;
    end else if (base_a_tick) begin
      base_a_ff <= 5'h00;
      pre_a_ff <= pre_a_ff + 8'h01;
    end else begin
      base_a_ff <= base_a_ff + 5'h01;
    end
  end
  assign base_a_tick = (base_a_ff == A_LAST);

  // Module B runs on the same scheme with half the base period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_b_ff <= 5'h00;
      pre_b_ff <= 8'h00;
    end else if (base_b_tick) begin
      base_b_ff <= 5'h00;
      pre_b_ff <= pre_b_ff + 8'h01;
    end else begin
      base_b_ff <= base_b_ff + 5'h01;
    end
  end
  assign base_b_tick = (base_b_ff == B_LAST);

  // Pins are taken as synchronous; one stage of history gives edges.
  // There is no synchroniser here: a pin that changes off the clock edge
  // would need two more flip-flops in front of this block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_ff <= 3'h0;
      cap_d_ff <= 1'b0;
    end else begin
      pin_d_ff <= timer_gate_clock_in;
      cap_d_ff <= capture_trigger_in;
    end
  end
  assign pin_rise = timer_gate_clock_in & ~pin_d_ff;
  // The capture edge is chosen by the aux B falling-edge option.
  // Falling-edge capture suits timing the low phase of an input.
  assign cap_event = ctrl_ff[T_B_AUX][F_OPT] & (ctrl_ff[T_B_AUX][F_TOG_FALL] ?
                     (cap_d_ff & ~capture_trigger_in) : (capture_trigger_in & ~cap_d_ff));

  // Latch transitions are known in the wrap cycle, so no extra delay.
  // A reload on the same edge therefore replaces the wrapped value without a gap.
  assign tog_a_rise = wrap[T_A_CORE] & ~core_a_toggle_latch_ff;
  assign tog_a_fall = wrap[T_A_CORE] & core_a_toggle_latch_ff;

  // Count enables and directions of all five timers.
  // One process drives every bit of step and down, so each has a single driver.
  // Core A set to toggle mode has nothing to count and stands still; core B ignores its mode.
  always_comb begin
    logic en;
    logic [15:0] c;
    en = 1'b0;
    c = CTRL_RST;
    for (int i = T_A_LOW; i <= T_A_HIGH; i++) begin
      c = ctrl_ff[i];
      case (gpt_mode_t'(c[F_MODE_HI:F_MODE_LO]))
        GPT_TIMER: en = pre_tick(base_a_tick, pre_a_ff, c[F_PRE_HI:F_PRE_LO]);
        GPT_GATED: en = pre_tick(base_a_tick, pre_a_ff, c[F_PRE_HI:F_PRE_LO])
                        & (timer_gate_clock_in[i] == c[F_GPOL]);
        GPT_COUNTER: en = pin_rise[i];
        GPT_TOGGLE: en = (i != T_A_CORE) & wrap[T_A_CORE];
        default: en = 1'b0;
      endcase
      // Aux timers acting as reload or capture registers do not count.
      step[i] = c[F_RUN] & en & ((i == T_A_CORE) ||
                (gpt_func_t'(c[F_FUNC_HI:F_FUNC_LO]) == GPT_FN_COUNT));
      down[i] = c[F_DOWN] ^ (c[F_XDIR] & timer_dir_in[i]);
    end
    // Module B: the core always counts prescaled ticks, and software alone
    // sets the direction of both timers, since module B has no direction pins.
    step[T_B_CORE] = ctrl_ff[T_B_CORE][F_RUN] & pre_tick(base_b_tick, pre_b_ff,
                     ctrl_ff[T_B_CORE][F_PRE_HI:F_PRE_LO]);
    case (gpt_mode_t'(ctrl_ff[T_B_AUX][F_MODE_HI:F_MODE_LO]))
      GPT_TOGGLE: step[T_B_AUX] = ctrl_ff[T_B_AUX][F_RUN] & wrap[T_B_CORE];
      GPT_TIMER: step[T_B_AUX] = ctrl_ff[T_B_AUX][F_RUN] & pre_tick(base_b_tick,
                                 pre_b_ff, ctrl_ff[T_B_AUX][F_PRE_HI:F_PRE_LO]);
      default: step[T_B_AUX] = 1'b0;
    endcase
    down[T_B_CORE] = ctrl_ff[T_B_CORE][F_DOWN];
    down[T_B_AUX] = ctrl_ff[T_B_AUX][F_DOWN];
  end

  // Loads: a software write always beats a hardware load.
  // Hardware loads of one timer are ordered so that the first request here
  // takes effect; later ones look at ld before they write it.
  always_comb begin
    logic trig;
    logic [15:0] c;
    trig = 1'b0;
    c = CTRL_RST;
    for (int i = 0; i < NUM_TMR; i++) begin
      ld[i] = sw_cnt_wr[i];
      ld_val[i] = pwdata[15:0];
    end
    flag_set = FLAGS_RST;
    // Aux timers of module A: capture from core, or reload the core.
    for (int j = T_A_LOW; j <= T_A_HIGH; j += 2) begin
      c = ctrl_ff[j];
      if (gpt_func_t'(c[F_FUNC_HI:F_FUNC_LO]) == GPT_FN_CAPTURE && pin_rise[j]) begin
        flag_set[j] = 1'b1;
        if (!sw_cnt_wr[j]) begin
          ld[j] = 1'b1;
          ld_val[j] = cnt[T_A_CORE];
        end
      end
      trig = c[F_TRIG_TOG] ? (c[F_TOG_FALL] ? tog_a_fall : tog_a_rise) : pin_rise[j];
      // Low aux on one edge and high aux on the other alternate for PWM.
      if (gpt_func_t'(c[F_FUNC_HI:F_FUNC_LO]) == GPT_FN_RELOAD && trig &&
          !sw_cnt_wr[T_A_CORE] && !ld[T_A_CORE]) begin
        ld[T_A_CORE] = 1'b1;
        ld_val[T_A_CORE] = cnt[j];
      end
    end
    // Core B wrap may reload it from the capture register.
    if (wrap[T_B_CORE] && ctrl_ff[T_B_CORE][F_OPT] && !sw_cnt_wr[T_B_CORE]) begin
      ld[T_B_CORE] = 1'b1;
      ld_val[T_B_CORE] = capture_reload_ff;
    end
    // Optional clear of aux B after its value was captured.
    if (cap_event && ctrl_ff[T_B_AUX][F_OPT2] && !sw_cnt_wr[T_B_AUX]) begin
      ld[T_B_AUX] = 1'b1;
      ld_val[T_B_AUX] = CNT_RST;
    end
    for (int i = 0; i < NUM_TMR; i++) begin
      if (wrap[i]) begin
        flag_set[i] = 1'b1;
      end
    end
    flag_set[CAP_FLAG] = cap_event;
  end

  // The five counters share one structure.
  // Each instance sees only its own strobes; all cross-timer logic stays above.
  for (genvar g = 0; g < NUM_TMR; g++) begin : g_cnt
    gpt_counter u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .step(step[g]),
      .down(down[g]),
      .load(ld[g]),
      .load_val(ld_val[g]),
      .count_ff(cnt[g]),
      .wrap(wrap[g])
    );
  end

  // Toggle latches invert on every wrap of their core timer.
  // Core B's latch has no pin; it only clocks aux B in toggle mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_toggle_latch_ff <= 1'b0;
      core_b_toggle_latch_ff <= 1'b0;
    end else begin
      core_a_toggle_latch_ff <= core_a_toggle_latch_ff ^ wrap[T_A_CORE];
      core_b_toggle_latch_ff <= core_b_toggle_latch_ff ^ wrap[T_B_CORE];
    end
  end
  // The pin shows the latch only when the core A output is enabled.
  assign core_a_toggle_out = core_a_toggle_latch_ff & ctrl_ff[T_A_CORE][F_OPT];

  // Bus decode; the slave never stalls, so pready stays high.
  // Zero wait states keep the bus simple; the cost is that read data must be
  // ready by the access phase, which the setup-phase capture below provides.
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_FLAGS) &&
              (paddr < OFS_CTRL0 + 8'(NUM_TMR) * OFS_STEP ||
               (paddr >= OFS_CNT0 && paddr < OFS_CNT0 + 8'(NUM_TMR) * OFS_STEP) ||
               paddr >= OFS_CAP_RELOAD);
    for (int i = 0; i < NUM_TMR; i++) begin
      sw_cnt_wr[i] = wr_en && (paddr == OFS_CNT0 + 8'(i) * OFS_STEP);
    end
  end
  // Refused accesses change nothing: unmapped writes decode to no register.
  assign pslverr = psel & penable & ~addr_ok;

  // Control words are plain software storage.
  // Fields take effect on the edge after the write, so a running timer never
  // sees half of an old and half of a new control word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        ctrl_ff[i] <= CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_TMR; i++) begin
        if (wr_en && paddr == OFS_CTRL0 + 8'(i) * OFS_STEP) begin
          ctrl_ff[i] <= pwdata[15:0];
        end
      end
    end
  end

  // Capture register: a capture event beats a software write.
  // Software loses a same-cycle collision so that no capture event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reload_ff <= CNT_RST;
    end else if (cap_event) begin
      capture_reload_ff <= cnt[T_B_AUX];
    end else if (wr_en && paddr == OFS_CAP_RELOAD) begin
      capture_reload_ff <= pwdata[15:0];
    end
  end

  // Flags clear by writing ones; a set in the same cycle wins.
  // Clearing with ones lets software acknowledge one flag without a read first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= FLAGS_RST;
    end else if (wr_en && paddr == OFS_FLAGS) begin
      flags_ff <= (flags_ff & ~pwdata[5:0]) | flag_set;
    end else begin
      flags_ff <= flags_ff | flag_set;
    end
  end
  assign timer_flags = flags_ff;

  // Read data is sampled in the setup phase so it comes from a flop.
  // The value shown is the one from the setup cycle; a count that moves during
  // the access phase shows up in the next read.
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_TMR; i++) begin
      if (paddr == OFS_CTRL0 + 8'(i) * OFS_STEP) begin
        rd_mux = {16'h0000, ctrl_ff[i]};
      end
      if (paddr == OFS_CNT0 + 8'(i) * OFS_STEP) begin
        rd_mux = {16'h0000, cnt[i]};
      end
    end
    if (paddr == OFS_CAP_RELOAD) begin
      rd_mux = {16'h0000, capture_reload_ff};
    end
    if (paddr == OFS_FLAGS) begin
      rd_mux = {26'h0, flags_ff};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// ==== dv/gpt_timer_units_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the timer block at its ports; figures follow the register map.
module gpt_timer_units_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] timer_gate_clock_in,
  input wire logic [2:0] timer_dir_in,
  input wire logic capture_trigger_in,
  input wire logic core_a_toggle_out,
  input wire logic [5:0] timer_flags
);
  import gpt_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // High when the address hits one of the mapped words.
  logic hit;
  assign hit = (paddr[1:0] == 2'h0) && (paddr <= 8'h10 || paddr == 8'h40 || paddr == 8'h44
    || (paddr >= 8'h20 && paddr <= 8'h30));
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !hit |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (psel && penable && hit |-> !pslverr)
    else $error("mapped access refused");
  a_err_only_access: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_read_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_refused_zero: assert property (psel && penable && !pwrite && pslverr |->
    prdata == 32'h0)
    else $error("refused read not zero");
  a_cap_flag: assert property ($rose(timer_flags[CAP_FLAG]) |->
    $past(capture_trigger_in) && !$past(capture_trigger_in, 2))
    else $error("capture flag without pin edge");
  a_flag_sticky: assert property (|($past(timer_flags) & ~timer_flags) |->
    $past(psel && penable && pwrite) && $past(paddr) == OFS_FLAGS)
    else $error("flag dropped without clear");
  a_toggle_cause: assert property ($changed(core_a_toggle_out) |->
    timer_flags[T_A_CORE] || $past(psel && penable && pwrite))
    else $error("toggle output moved without wrap");
endmodule
bind gpt_timer_units gpt_timer_units_checker i_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_gate_clock_in(timer_gate_clock_in), .timer_dir_in(timer_dir_in),
  .capture_trigger_in(capture_trigger_in), .core_a_toggle_out(core_a_toggle_out),
  .timer_flags(timer_flags));
`default_nettype wire

// ==== dv/gpt_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side pin model: gate, count, direction and capture lines.
module gpt_pins (
  input wire logic pclk,
  output var logic [2:0] gate,
  output var logic [2:0] dir,
  output var logic cap
);
  // Quiet levels at time zero, so the block never samples unknown pins.
  initial begin
    gate = 3'h0;
    dir = 3'h0;
    cap = 1'b0;
  end
  // Sets a steady gate level, held until the next call.
  task automatic level(input logic [2:0] v);
    @(posedge pclk);
    gate <= v;
  endtask
  // Sets the direction pins.
  task automatic steer(input logic [2:0] v);
    @(posedge pclk);
    dir <= v;
  endtask
  // Each level lasts two clocks so the clocked edge detector cannot miss it.
  task automatic pulse(input logic [2:0] m, input logic c);
    @(posedge pclk);
    gate <= gate | m;
    cap <= c;
    repeat (2) @(posedge pclk);
    gate <= gate & ~m;
    cap <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== dv/gpt_timer_units_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Register-level tests of the timer units over APB, pins from the partner.
module gpt_timer_units_bench;
  import gpt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tog, cin, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, x;
  logic [2:0] gin, din;
  logic [5:0] flags;
  int n_mismatch, checks_done;
  int hi; // Cycles with the toggle output high.
  gpt_timer_units i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_gate_clock_in(gin), .timer_dir_in(din),
    .capture_trigger_in(cin), .core_a_toggle_out(tog), .timer_flags(flags));
  gpt_pins i_pins (.pclk(pclk), .gate(gin), .dir(din), .cap(cin));
  // 40 MHz bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ctl(input int i);
    return OFS_CTRL0 + 8'(4 * i);
  endfunction
  function automatic logic [7:0] cnt(input int i);
    return OFS_CNT0 + 8'(4 * i);
  endfunction
  // One transfer; the idle edge first keeps two calls from clashing.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  // Ticks over n+3 clocks, the distance between the two read samples.
  task automatic span(input logic [7:0] a, input int n, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    x = q;
    repeat (n) @(posedge pclk);
    xfer(a, 1'b0, 32'h0);
    chk(q - x, exp);
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cuts a hang short; the tests need a few thousand clocks.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_TMR; i++) begin
      rd(ctl(i), 32'h0);
      rd(cnt(i), 32'h0);
    end
    rd(OFS_CAP_RELOAD, 32'h0);
    rd(OFS_FLAGS, 32'h0);
    rd(8'h48, 32'h0);
    chk(32'(e), 32'h1);
    // Timer mode at the finest period, then one prescaler step slower.
    wr(ctl(T_A_LOW), 32'h0020);
    span(cnt(T_A_LOW), 205, 32'h1A);
    wr(ctl(T_A_LOW), 32'h0021);
    span(cnt(T_A_LOW), 205, 32'hD);
    // Gated mode, gate active high: idle while low, full rate while high.
    wr(ctl(T_A_LOW), 32'h0128);
    span(cnt(T_A_LOW), 205, 32'h0);
    i_pins.level(3'b001);
    span(cnt(T_A_LOW), 205, 32'h1A);
    i_pins.level(3'b000);
    // Event counting through a wrap, with the toggle latch on the pin.
    wr(cnt(T_A_CORE), 32'hFFFE);
    wr(ctl(T_A_CORE), 32'h2038);
    repeat (3) i_pins.pulse(3'b010, 1'b0);
    rd(cnt(T_A_CORE), 32'h1);
    chk(32'(tog), 32'h1);
    xfer(OFS_FLAGS, 1'b0, 32'h0);
    chk(32'(q[T_A_CORE]), 32'h1);
    // The direction pin turns the count round through zero.
    i_pins.steer(3'b010);
    wr(ctl(T_A_CORE), 32'h20B8);
    repeat (2) i_pins.pulse(3'b010, 1'b0);
    rd(cnt(T_A_CORE), 32'hFFFF);
    chk(32'(tog), 32'h0);
    wr(OFS_FLAGS, 32'h3F);
    rd(OFS_FLAGS, 32'h0);
    // Capture of the stopped core into the high aux timer, then a reload.
    wr(ctl(T_A_CORE), 32'h2000);
    wr(ctl(T_A_HIGH), 32'h0420);
    i_pins.pulse(3'b100, 1'b0);
    rd(cnt(T_A_HIGH), 32'hFFFF);
    wr(ctl(T_A_LOW), 32'h0220);
    wr(cnt(T_A_LOW), 32'h4321);
    i_pins.pulse(3'b001, 1'b0);
    rd(cnt(T_A_CORE), 32'h4321);
    // Continuous PWM: low aux reloads on the latch rising, high aux on falling.
    wr(cnt(T_A_LOW), 32'hFFF0);
    wr(cnt(T_A_HIGH), 32'hFFF8);
    wr(ctl(T_A_LOW), 32'h0A00);
    wr(ctl(T_A_HIGH), 32'h1A00);
    wr(cnt(T_A_CORE), 32'hFFF0);
    wr(ctl(T_A_CORE), 32'h2020);
    repeat (400) @(posedge pclk);
    // Two full periods of 24 steps: 16 high, 8 low, 8 clocks per step.
    hi = 0;
    repeat (384) begin
      @(negedge pclk);
      hi += int'(tog);
    end
    chk(32'(hi), 32'h100);
    // Module B: capture with clear, timer rate, core wrap reload.
    wr(cnt(T_B_AUX), 32'h0055);
    wr(ctl(T_B_AUX), 32'h6000);
    i_pins.pulse(3'b000, 1'b1);
    rd(OFS_CAP_RELOAD, 32'h55);
    rd(cnt(T_B_AUX), 32'h0);
    xfer(OFS_FLAGS, 1'b0, 32'h0);
    chk(32'(q[CAP_FLAG]), 32'h1);
    wr(ctl(T_B_AUX), 32'h0020);
    span(cnt(T_B_AUX), 97, 32'h19);
    wr(cnt(T_B_CORE), 32'hFFFE);
    wr(ctl(T_B_CORE), 32'h2020);
    repeat (97) @(posedge pclk);
    xfer(cnt(T_B_CORE), 1'b0, 32'h0);
    chk(32'(q >= 32'h6B && q <= 32'h6C), 32'h1);
    xfer(OFS_FLAGS, 1'b0, 32'h0);
    chk(32'(q[T_B_CORE]), 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
